// [bench/multichannel_align_status_ctrl_tb.sv]
`timescale 1ns/10ps
`include "mcas_cfg.svh"
module multichannel_align_status_ctrl_tb;
    import mcas_pkg::*;
    localparam logic [19:0] A_QA_AL = {`MCAS_IDX_QA_ALIGN, 2'b00};
    localparam logic [19:0] A_QA_SY = {`MCAS_IDX_QA_SYNC, 2'b00};
    localparam logic [19:0] A_QB_AL = {`MCAS_IDX_QB_ALIGN, 2'b00};
    localparam logic [19:0] A_QB_SY = {`MCAS_IDX_QB_SYNC, 2'b00};
    localparam logic [19:0] A_CLK = {`MCAS_IDX_CLK_SEL, 2'b00};
    localparam logic [19:0] A_THL = {`MCAS_IDX_THR_LO, 2'b00};
    localparam logic [19:0] A_THH = {`MCAS_IDX_THR_HI, 2'b00};
    localparam logic [19:0] A_OCT = {`MCAS_IDX_OCT_STAT, 2'b00};
    localparam logic [19:0] A_IST = {`MCAS_IDX_IRQ_STAT, 2'b00};
    localparam logic [19:0] A_IMK = {`MCAS_IDX_IRQ_MASK, 2'b00};
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, octal_resync_trigger;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [4:0] rx_fifo_low_thr;
    logic [7:0] fifo_ptr_reset;
    sync_events_s events;
    clk_src_s clk_src;
    int n_fail = 0;
    int cmp_count = 0;
    int n_trig = 0;
    int n_ptr = 0;

    multichannel_align_status_ctrl i_multichannel_align_status_ctrl (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .events(events), .clk_src(clk_src),
        .rx_fifo_low_thr(rx_fifo_low_thr), .octal_resync_trigger(octal_resync_trigger),
        .fifo_ptr_reset(fifo_ptr_reset), .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Pulses are counted between edges so a flop update never races the count.
    always @(negedge pclk) begin
        if (octal_resync_trigger === 1'b1) n_trig++;
        if (fifo_ptr_reset === 8'hFF) n_ptr++;
    end

    task automatic end_sim();
        if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Pready is a flop, so reading it at the rising edge gives the level the slave presented.
    // Two falling edges pass before returning, so flop outputs and the one-cycle-later
    // interrupt have settled when the caller looks at them.
    task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic er);
        bit done;
        done = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                rd = prdata;
                er = pslverr;
                done = 1;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!done) begin
            chk("pready timeout", 32'h1, 32'h0);
            end_sim();
        end
        repeat (2) @(negedge pclk);
    endtask

    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, d, 4'hF, rd, er);
        chk("write pslverr", 32'h0, {31'h0, er});
    endtask

    task automatic rdchk(input string what, input logic [19:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h0, 4'h0, rd, er);
        chk(what, exp, rd);
        chk("read pslverr", 32'h0, {31'h0, er});
    endtask

    task automatic t_reset_values();
        logic [19:0] al [10];
        al = '{A_QA_AL, A_QA_SY, A_QB_AL, A_QB_SY, A_CLK, A_THL, A_THH, A_OCT, A_IST, A_IMK};
        foreach (al[i]) rdchk("reset value", al[i], 32'h0);
        chk("clk_src reset", 32'h0, {24'h0, clk_src});
        chk("irq reset", 32'h0, {31'h0, irq});
    endtask

    task automatic t_controls();
        logic [31:0] rd;
        logic er;
        wr(A_CLK, 32'h0000_00E4);
        chk("qa tx src", 32'h0, {30'h0, clk_src.quad_a_tx_clk_src});
        chk("qa rx src", 32'h1, {30'h0, clk_src.quad_a_rx_clk_src});
        chk("qb tx src", 32'h2, {30'h0, clk_src.quad_b_tx_clk_src});
        chk("qb rx src", 32'h3, {30'h0, clk_src.quad_b_rx_clk_src});
        rdchk("clk sel readback", A_CLK, 32'hE4);
        apb(1'b1, A_CLK, 32'h0000_001B, 4'hE, rd, er);
        rdchk("strobe-less write", A_CLK, 32'hE4);
        wr(A_THL, 32'h0000_00FF);
        wr(A_THH, 32'h0000_00FB);
        rdchk("thr low reserved", A_THL, 32'hE0);
        rdchk("thr high reserved", A_THH, 32'h03);
        chk("thr all ones", 32'h1F, {27'h0, rx_fifo_low_thr});
        wr(A_THL, 32'h0000_0020);
        wr(A_THH, 32'h0000_0002);
        chk("thr 17", 32'h11, {27'h0, rx_fifo_low_thr});
        chk("no resync", 32'h0, n_trig);
    endtask

    task automatic t_status();
        @(posedge pclk);
        events.word_align_done <= 8'hA5;
        events.lane_group_aligned <= 8'h3C;
        events.pair_fifo_overflow <= 4'b0110;
        events.quad_fifo_overflow <= 2'b11;
        events.pair_out_of_sync <= 4'b1101;
        events.quad_out_of_sync <= 2'b10;
        events.octal_fifo_overflow <= 1'b1;
        events.octal_out_of_sync <= 1'b1;
        @(posedge pclk);
        events.pair_fifo_overflow <= 4'h0;
        events.quad_fifo_overflow <= 2'h0;
        events.pair_out_of_sync <= 4'h0;
        events.quad_out_of_sync <= 2'h0;
        events.octal_fifo_overflow <= 1'b0;
        events.octal_out_of_sync <= 1'b0;
        rdchk("qa align", A_QA_AL, 32'hC5);
        rdchk("qb align", A_QB_AL, 32'h3A);
        wr(A_QA_SY, 32'h0000_00FF);
        rdchk("qa sync", A_QA_SY, 32'h0E);
        rdchk("qb sync", A_QB_SY, 32'h3D);
        wr(A_OCT, 32'h0000_0000);
        rdchk("octal status", A_OCT, 32'h03);
        @(posedge pclk);
        events.word_align_done <= 8'h00;
        events.lane_group_aligned <= 8'h00;
        repeat (2) @(posedge pclk);
        rdchk("qa align cleared", A_QA_AL, 32'h00);
    endtask

    task automatic t_irq();
        rdchk("irq stat", A_IST, 32'hF);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(A_IMK, 32'h0000_0001);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(A_IST, 32'h0000_0001);
        rdchk("irq stat w1c", A_IST, 32'hE);
        chk("irq after clear", 32'h0, {31'h0, irq});
        wr(A_IMK, 32'h0000_000F);
        chk("irq other bits", 32'h1, {31'h0, irq});
        wr(A_IST, 32'h0000_000F);
        chk("irq all clear", 32'h0, {31'h0, irq});
    endtask

    task automatic t_resync();
        wr(A_THH, 32'h0000_0006);
        chk("resync pulse", 32'h1, n_trig);
        chk("ptr reset pulse", 32'h1, n_ptr);
        rdchk("flags cleared", A_QA_SY, 32'h00);
        rdchk("octal cleared", A_OCT, 32'h00);
        rdchk("resync readback", A_THH, 32'h06);
        wr(A_THH, 32'h0000_0006);
        chk("no repeat pulse", 32'h1, n_trig);
        wr(A_THH, 32'h0000_0002);
        wr(A_THH, 32'h0000_0006);
        chk("second pulse", 32'h2, n_trig);
        chk("second ptr reset", 32'h2, n_ptr);
        chk("thr kept", 32'h11, {27'h0, rx_fifo_low_thr});
    endtask

    // An event that arrives while the clock enable is low must leave no trace.
    task automatic t_ce();
        @(posedge pclk);
        ce <= 1'b0;
        events.octal_fifo_overflow <= 1'b1;
        @(posedge pclk);
        events.octal_fifo_overflow <= 1'b0;
        @(posedge pclk);
        ce <= 1'b1;
        rdchk("ce freeze", A_OCT, 32'h0);
    endtask

    task automatic t_unmapped();
        logic [31:0] rd;
        logic er;
        apb(1'b1, 20'hC2818, 32'h0000_00FF, 4'hF, rd, er);
        chk("unmapped write err", 32'h1, {31'h0, er});
        apb(1'b0, 20'hC2818, 32'h0, 4'h0, rd, er);
        chk("unmapped read err", 32'h1, {31'h0, er});
        chk("unmapped read data", 32'h0, rd);
        rdchk("clk sel intact", A_CLK, 32'hE4);
    endtask

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        events = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_controls();
        t_status();
        t_irq();
        t_resync();
        t_ce();
        t_unmapped();
        end_sim();
    end
endmodule // multichannel_align_status_ctrl_tb

// [include/mcas_cfg.svh]
`ifndef MCAS_CFG_SVH
`define MCAS_CFG_SVH

// Register indices as printed; byte address is four times the index.
`define MCAS_IDX_QA_ALIGN 18'h30805
`define MCAS_IDX_QA_SYNC 18'h30814
`define MCAS_IDX_QB_ALIGN 18'h30905
`define MCAS_IDX_QB_SYNC 18'h30914
`define MCAS_IDX_CLK_SEL 18'h30A00
`define MCAS_IDX_THR_LO 18'h30A01
`define MCAS_IDX_THR_HI 18'h30A02
`define MCAS_IDX_OCT_STAT 18'h30A03
`define MCAS_IDX_IRQ_STAT 18'h30A04
`define MCAS_IDX_IRQ_MASK 18'h30A05

// Field positions.
`define MCAS_QA_TX_LSB 0
`define MCAS_QA_RX_LSB 2
`define MCAS_QB_TX_LSB 4
`define MCAS_QB_RX_LSB 6
`define MCAS_THR_LO_LSB 5
`define MCAS_RESYNC_BIT 2
`define MCAS_OCT_OVFL_BIT 0
`define MCAS_OCT_OOS_BIT 1

// Interrupt status bits.
`define MCAS_IRQ_QA 0
`define MCAS_IRQ_QB 1
`define MCAS_IRQ_OCT_OVFL 2
`define MCAS_IRQ_OCT_OOS 3

// Reset values.
`define MCAS_RST_BYTE 8'h00
`define MCAS_RST_IRQ 4'h0
`define MCAS_RST_WORD 32'h0000_0000

// Highest useful receive FIFO low-address threshold.
`define MCAS_THR_USEFUL_MAX 5'h11

`endif

// [include/mcas_pkg.sv]
package mcas_pkg;

    typedef struct packed {
        logic [7:0] word_align_done;
        logic [7:0] lane_group_aligned;
        logic [3:0] pair_fifo_overflow;
        logic [1:0] quad_fifo_overflow;
        logic [3:0] pair_out_of_sync;
        logic [1:0] quad_out_of_sync;
        logic octal_fifo_overflow;
        logic octal_out_of_sync;
    } sync_events_s;

    typedef struct packed {
        logic [1:0] quad_a_tx_clk_src;
        logic [1:0] quad_a_rx_clk_src;
        logic [1:0] quad_b_tx_clk_src;
        logic [1:0] quad_b_rx_clk_src;
    } clk_src_s;

    typedef enum logic [3:0] {
        SEL_NONE = 4'h0,
        SEL_QA_ALIGN = 4'h1,
        SEL_QA_SYNC = 4'h2,
        SEL_QB_ALIGN = 4'h3,
        SEL_QB_SYNC = 4'h4,
        SEL_CLK = 4'h5,
        SEL_THR_LO = 4'h6,
        SEL_THR_HI = 4'h7,
        SEL_OCT = 4'h8,
        SEL_IRQ_STAT = 4'h9,
        SEL_IRQ_MASK = 4'hA
    } reg_sel_e;

endpackage

// [verilog/multichannel_align_status_ctrl.sv]
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`include "mcas_cfg.svh"
// Summary of operation
// - Low nibble shows per-lane word alignment.
// - High nibble shows per-lane group alignment.
// - Pair FIFO overflow sets bits 0 and 1.
// - Quad FIFO overflow sets bit 2.
// - Pair out-of-sync sets bits 3 and 4.
// - Quad out-of-sync sets bit 5; 6-7 reserved.
// - Bits 0-1 pick quad A transmit clock.
// - Bits 2-3 pick quad A receive clock.
// - Bits 4-7 pick quad B clocks.
// - Threshold low bits at bits 5-7.
// - Threshold high bits at bits 0-1.
// - Rising resync bit resynchronizes all lanes.
// - Octal FIFO overflow sets status bit 0.
// - Octal out-of-sync sets status bit 1.
// - Each lane keeps its own alignment status; lanes share pclk, ce and the per-quad sync flags.
// - Each lane follows its own data stream.
// - Resync resets the lanes' FIFO pointers.
module multichannel_align_status_ctrl #(
    parameter int ADDR_W = 20,
    parameter int LANES = 8
) (
    // Clock, reset and enable.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Events from the lanes and alignment FIFOs.
    input mcas_pkg::sync_events_s events,
    // Controls toward the transceiver core.
    output mcas_pkg::clk_src_s clk_src,
    output logic [4:0] rx_fifo_low_thr,
    output logic octal_resync_trigger,
    output logic [LANES-1:0] fifo_ptr_reset,
    // Interrupt.
    output logic irq
);
    import mcas_pkg::*;

    if (ADDR_W < 20) begin : g_chk_addr
        $error("ADDR_W must reach the highest register address.");
    end
    if (LANES != 8) begin : g_chk_lanes
        $error("The register layout serves exactly eight lanes.");
    end

    logic [7:0] clk_sel_ff;
    logic [2:0] thr_lo_ff;
    logic [1:0] thr_hi_ff;
    logic resync_bit_ff;
    logic [7:0] word_align_ff;
    logic [7:0] group_align_ff;
    logic [5:0] quad_sync_ff [2];
    logic [5:0] nxt_quad_sync [2];
    logic [1:0] octal_ff;
    logic [1:0] nxt_octal;
    logic [3:0] irq_stat_ff;
    logic [3:0] irq_mask_ff;
    logic [3:0] irq_event;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic irq_ff;
    logic resync_pulse_ff;
    logic [LANES-1:0] fifo_ptr_rst_ff;
    reg_sel_e sel;
    reg_sel_e sel_ff;
    logic [31:0] nxt_prdata;
    logic setup;
    logic wr_en;
    logic resync_fire;

    // Setup phase decode; the answer is registered so every bus output is a flop.
    assign setup = psel & ~penable;

    always_comb begin
        case (paddr[19:2])
            `MCAS_IDX_QA_ALIGN: sel = SEL_QA_ALIGN;
            `MCAS_IDX_QA_SYNC: sel = SEL_QA_SYNC;
            `MCAS_IDX_QB_ALIGN: sel = SEL_QB_ALIGN;
            `MCAS_IDX_QB_SYNC: sel = SEL_QB_SYNC;
            `MCAS_IDX_CLK_SEL: sel = SEL_CLK;
            `MCAS_IDX_THR_LO: sel = SEL_THR_LO;
            `MCAS_IDX_THR_HI: sel = SEL_THR_HI;
            `MCAS_IDX_OCT_STAT: sel = SEL_OCT;
            `MCAS_IDX_IRQ_STAT: sel = SEL_IRQ_STAT;
            `MCAS_IDX_IRQ_MASK: sel = SEL_IRQ_MASK;
            default: sel = SEL_NONE;
        endcase
    end

    // Reserved bits and upper bytes are forced to zero here.
    always_comb begin
        nxt_prdata = `MCAS_RST_WORD;
        case (sel)
            SEL_QA_ALIGN: nxt_prdata[7:0] = {group_align_ff[3:0], word_align_ff[3:0]};
            SEL_QA_SYNC: nxt_prdata[7:0] = {2'h0, quad_sync_ff[0]};
            SEL_QB_ALIGN: nxt_prdata[7:0] = {group_align_ff[7:4], word_align_ff[7:4]};
            SEL_QB_SYNC: nxt_prdata[7:0] = {2'h0, quad_sync_ff[1]};
            SEL_CLK: nxt_prdata[7:0] = clk_sel_ff;
            SEL_THR_LO: nxt_prdata[7:0] = {thr_lo_ff, 5'h00};
            SEL_THR_HI: nxt_prdata[7:0] = {5'h00, resync_bit_ff, thr_hi_ff};
            SEL_OCT: nxt_prdata[7:0] = {6'h00, octal_ff};
            SEL_IRQ_STAT: nxt_prdata[3:0] = irq_stat_ff;
            SEL_IRQ_MASK: nxt_prdata[3:0] = irq_mask_ff;
            default: nxt_prdata = `MCAS_RST_WORD;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= `MCAS_RST_WORD;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            sel_ff <= SEL_NONE;
        end else if (ce) begin
            pready_ff <= setup;
            if (setup) begin
                prdata_ff <= pwrite ? `MCAS_RST_WORD : nxt_prdata;
                pslverr_ff <= (sel == SEL_NONE);
                sel_ff <= sel;
            end
        end
    end

    // A write lands at the access edge; a write without lane 0 enabled is dropped.
    assign wr_en = psel & penable & pready_ff & pwrite & ~pslverr_ff & pstrb[0] & ce;
    assign resync_fire = wr_en & (sel_ff == SEL_THR_HI) &
        pwdata[`MCAS_RESYNC_BIT] & ~resync_bit_ff;

    // Writable control bytes; of the status bytes only the interrupt status takes writes, as write one to clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_sel_ff <= `MCAS_RST_BYTE;
            thr_lo_ff <= 3'h0;
            thr_hi_ff <= 2'h0;
            resync_bit_ff <= 1'b0;
            irq_mask_ff <= `MCAS_RST_IRQ;
        end else if (wr_en) begin
            case (sel_ff)
                SEL_CLK: clk_sel_ff <= pwdata[7:0];
                SEL_THR_LO: thr_lo_ff <= pwdata[7:5];
                SEL_THR_HI: begin
                    thr_hi_ff <= pwdata[1:0];
                    resync_bit_ff <= pwdata[`MCAS_RESYNC_BIT];
                end
                SEL_IRQ_MASK: irq_mask_ff <= pwdata[3:0];
                default: clk_sel_ff <= clk_sel_ff;
            endcase
        end
    end

    // Field value equals channel index because bit 0 carries the first printed digit.
    assign clk_src.quad_a_tx_clk_src = clk_sel_ff[`MCAS_QA_TX_LSB +: 2];
    assign clk_src.quad_a_rx_clk_src = clk_sel_ff[`MCAS_QA_RX_LSB +: 2];
    assign clk_src.quad_b_tx_clk_src = clk_sel_ff[`MCAS_QB_TX_LSB +: 2];
    assign clk_src.quad_b_rx_clk_src = clk_sel_ff[`MCAS_QB_RX_LSB +: 2];
    // Values above 17 are stored as written; the core decides what they mean.
    assign rx_fifo_low_thr = {thr_hi_ff, thr_lo_ff};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resync_pulse_ff <= 1'b0;
        end else if (ce) begin
            resync_pulse_ff <= resync_fire;
        end
    end

    // Each lane gets its own align status flops and pointer reset; the sync flags are shared per quad.
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                word_align_ff[l] <= 1'b0;
                group_align_ff[l] <= 1'b0;
                fifo_ptr_rst_ff[l] <= 1'b0;
            end else if (ce) begin
                word_align_ff[l] <= events.word_align_done[l];
                group_align_ff[l] <= events.lane_group_aligned[l];
                fifo_ptr_rst_ff[l] <= resync_fire;
            end
        end
    end

    // Sync flags are sticky until a resync; an event in the clear cycle survives.
    for (genvar q = 0; q < 2; q++) begin : g_quad
        logic [5:0] set;
        assign set = {events.quad_out_of_sync[q], events.pair_out_of_sync[2*q +: 2],
            events.quad_fifo_overflow[q], events.pair_fifo_overflow[2*q +: 2]};
        assign nxt_quad_sync[q] = resync_fire ? set : (quad_sync_ff[q] | set);
        assign irq_event[q] = |(set & ~quad_sync_ff[q]);
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                quad_sync_ff[q] <= 6'h00;
            end else if (ce) begin
                quad_sync_ff[q] <= nxt_quad_sync[q];
            end
        end
    end

    assign nxt_octal = (resync_fire ? 2'h0 : octal_ff) |
        {events.octal_out_of_sync, events.octal_fifo_overflow};
    assign irq_event[`MCAS_IRQ_OCT_OVFL] = events.octal_fifo_overflow &
        ~octal_ff[`MCAS_OCT_OVFL_BIT];
    assign irq_event[`MCAS_IRQ_OCT_OOS] = events.octal_out_of_sync &
        ~octal_ff[`MCAS_OCT_OOS_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            octal_ff <= 2'h0;
        end else if (ce) begin
            octal_ff <= nxt_octal;
        end
    end

    // Interrupt status: write one to clear, a new event wins over the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= `MCAS_RST_IRQ;
        end else if (ce) begin
            if (wr_en && sel_ff == SEL_IRQ_STAT) begin
                irq_stat_ff <= (irq_stat_ff & ~pwdata[3:0]) | irq_event;
            end else begin
                irq_stat_ff <= irq_stat_ff | irq_event;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else if (ce) begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign octal_resync_trigger = resync_pulse_ff;
    assign fifo_ptr_reset = fifo_ptr_rst_ff;
    assign irq = irq_ff;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_word_align;
        ce |=> word_align_ff == $past(events.word_align_done);
    endproperty
    a_word_align: assert property (p_word_align) else $error("Word align status lags input.");

    property p_group_align;
        ce |=> group_align_ff == $past(events.lane_group_aligned);
    endproperty
    a_group_align: assert property (p_group_align) else $error("Group align status wrong.");

    property p_pair_ovfl;
        ce && events.pair_fifo_overflow[1] |=> quad_sync_ff[0][1];
    endproperty
    a_pair_ovfl: assert property (p_pair_ovfl) else $error("Pair overflow flag not set.");

    property p_quad_ovfl_sticky;
        ce && !resync_fire && quad_sync_ff[1][2] |=> quad_sync_ff[1][2];
    endproperty
    a_quad_ovfl_sticky: assert property (p_quad_ovfl_sticky) else $error("Quad flag lost.");

    property p_pair_oos;
        ce && events.pair_out_of_sync[2] |=> quad_sync_ff[1][3];
    endproperty
    a_pair_oos: assert property (p_pair_oos) else $error("Pair out-of-sync flag not set.");

    property p_clk_write;
        wr_en && sel_ff == SEL_CLK |=> clk_src.quad_b_rx_clk_src == $past(pwdata[7:6]);
    endproperty
    a_clk_write: assert property (p_clk_write) else $error("Clock select not stored.");

    property p_thr_write;
        wr_en && sel_ff == SEL_THR_LO |=> rx_fifo_low_thr[2:0] == $past(pwdata[7:5]);
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("Threshold low bits wrong.");

    property p_resync;
        ce && resync_fire |=> fifo_ptr_reset == 8'hFF && octal_resync_trigger;
    endproperty
    a_resync: assert property (p_resync) else $error("Resync did not reach the lanes.");

    property p_resync_once;
        octal_resync_trigger && ce |=> !octal_resync_trigger;
    endproperty
    a_resync_once: assert property (p_resync_once) else $error("Resync pulse too long.");

    property p_octal_ovfl;
        ce && events.octal_fifo_overflow |=> octal_ff[0] ##1 (prdata[31:8] == 24'h000000);
    endproperty
    a_octal_ovfl: assert property (p_octal_ovfl) else $error("Octal overflow not set.");

    property p_unmapped;
        ce && setup && sel == SEL_NONE |=> pready && pslverr && prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped access not refused.");

    property p_irq;
        ce |=> irq == $past(|(irq_stat_ff & irq_mask_ff));
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt output mismatch.");

    c_resync: cover property (resync_fire ##1 fifo_ptr_reset == 8'hFF);
    c_irq: cover property (irq ##[1:20] !irq);
    c_read_sync: cover property (pready && !pwrite && prdata[5:0] != 6'h00);
    c_err: cover property (pready && pslverr);

endmodule // multichannel_align_status_ctrl
